//--- logic/psbr_responder.v
// Bus-side responder of the program store unit
`timescale 1ns/1ps
`default_nettype none
`include "psbr_consts.vh"

module psbr_responder #(
	parameter       SEG_BITS  = 6,
	parameter [5:0] SEG_BASE  = 6'h00,
	parameter [5:0] PORT_SEL  = 6'h01,
	parameter [15:0] VECTOR   = 16'h0080,
	parameter       STORE_AW  = 10
) (
	// Clock and reset
	input  wire        clock,
	input  wire        resetn,
	// CPU timing enables
	input  wire        phase_en,
	input  wire        write_en,
	// Cycle control code
	input  wire [4:0]  cycle_control_code,
	// Data bus, split
	input  wire [7:0]  data_in,
	output reg  [7:0]  data_out,
	output wire        data_oe,
	// Bus direction, open drain: pin low while oe is high
	output wire        bus_direction_n_out,
	output wire        bus_direction_n_oe,
	// Interrupt source status
	input  wire        irq_pending,
	// I/O port pins
	input  wire [7:0]  port_a_in,
	input  wire [7:0]  port_b_in,
	output reg  [7:0]  port_a_ff,
	output reg  [7:0]  port_b_ff,
	// Timer tick
	output reg         timer_tick_ff
);

	////////////////////////////////////////////////////////////////////
	reg  [15:0] main_program_counter_ff;
	reg  [15:0] stack_program_counter_ff;
	reg  [15:0] data_counter_reg_ff;
	reg  [15:0] nxt_pc0;
	reg  [15:0] nxt_pc1;
	reg  [15:0] nxt_dc;
	reg  [7:0]  nxt_data;
	reg         nxt_drive;
	reg         drive_ff;
	reg         precharged_ff;
	reg  [4:0]  timer_div_ff;
	reg  [7:0]  store_mem [0:(1<<STORE_AW)-1];
	reg  [15:0] mem_addr;
	reg         mem_read;
	reg  [15:0] add_base;
	reg         add_sign;
	wire [15:0] add_sum;
	wire [7:0]  mem_byte;
	wire        in_seg;
	wire        port_hit;
	wire        port_a_hit;
	wire        port_b_hit;
	wire [7:0]  port_rd;

	integer k;
	initial begin
		for (k = 0; k < (1<<STORE_AW); k = k + 1) begin
			store_mem[k] = 8'h00;
		end
	end

	psbr_addr_adder u_adder (
		.base     (add_base),
		.addend   (data_in),
		.sign_ext (add_sign),
		.sum      (add_sum)
	);

	////////////////////////////////////////////////////////////////////
	// Segment and port decode
	assign in_seg     = (mem_addr[15:16-SEG_BITS] == SEG_BASE[SEG_BITS-1:0]);
	assign mem_byte   = store_mem[mem_addr[STORE_AW-1:0]];
	// Port address sits in the accumulator byte the CPU drives on the bus
	assign port_hit   = (data_in[7:2] == PORT_SEL);
	assign port_a_hit = port_hit && (data_in[1:0] == `PSBR_PORT_A_LSB);
	assign port_b_hit = port_hit && (data_in[1:0] == `PSBR_PORT_B_LSB);
	assign port_rd    = port_a_hit ? port_a_in : port_b_in;

	always @* begin
		add_base = main_program_counter_ff;
		add_sign = 1'b1;
		mem_addr = main_program_counter_ff;
		case (cycle_control_code)
			`PSBR_CC_OPND_DC: mem_addr = data_counter_reg_ff;
			`PSBR_CC_ADD_DC: begin
				add_base = data_counter_reg_ff;
			end
			default: begin
				add_base = main_program_counter_ff;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Control code decode: bus response and counter next values
	always @* begin
		nxt_pc0   = main_program_counter_ff;
		nxt_pc1   = stack_program_counter_ff;
		nxt_dc    = data_counter_reg_ff;
		nxt_data  = `PSBR_BYTE_RST;
		nxt_drive = 1'b0;
		mem_read  = 1'b0;
		case (cycle_control_code)
			`PSBR_CC_FETCH, `PSBR_CC_OPND_PC: begin
				mem_read = 1'b1;
				nxt_pc0  = main_program_counter_ff + 16'h0001;
			end
			`PSBR_CC_BRANCH: begin
				mem_read = 1'b1;
				nxt_pc0  = add_sum;
			end
			`PSBR_CC_OPND_DC: begin
				mem_read = 1'b1;
				nxt_dc   = data_counter_reg_ff + 16'h0001;
			end
			`PSBR_CC_SWAP_PC: nxt_pc0 = stack_program_counter_ff;
			`PSBR_CC_STORE_DC: nxt_dc = data_counter_reg_ff + 16'h0001;
			`PSBR_CC_DC_HI: begin
				nxt_drive = 1'b1;
				nxt_data  = data_counter_reg_ff[15:8];
			end
			`PSBR_CC_PC1_HI: begin
				nxt_drive = 1'b1;
				nxt_data  = stack_program_counter_ff[15:8];
			end
			`PSBR_CC_CLR_PC: begin
				nxt_pc1 = main_program_counter_ff;
				nxt_pc0 = `PSBR_ADDR_RST;
			end
			`PSBR_CC_DC_LO: begin
				nxt_drive = 1'b1;
				nxt_data  = data_counter_reg_ff[7:0];
			end
			`PSBR_CC_ADD_DC: nxt_dc = add_sum;
			`PSBR_CC_PC1_LO: begin
				nxt_drive = 1'b1;
				nxt_data  = stack_program_counter_ff[7:0];
			end
			`PSBR_CC_PCLO_MEM: begin
				mem_read = 1'b1;
				nxt_pc0  = {main_program_counter_ff[15:8], mem_byte};
			end
			`PSBR_CC_INC_PC1: nxt_pc1 = main_program_counter_ff + 16'h0001;
			`PSBR_CC_DCLO_MEM: begin
				mem_read = 1'b1;
				nxt_pc0  = main_program_counter_ff + 16'h0001;
				nxt_dc   = {data_counter_reg_ff[15:8], mem_byte};
			end
			`PSBR_CC_VEC_LO: begin
				nxt_drive = irq_pending;
				nxt_data  = VECTOR[7:0];
				if (irq_pending) begin
					nxt_pc1 = main_program_counter_ff;
					nxt_pc0 = {main_program_counter_ff[15:8], VECTOR[7:0]};
				end
			end
			`PSBR_CC_DCHI_MEM: begin
				mem_read = 1'b1;
				nxt_pc0  = main_program_counter_ff + 16'h0001;
				nxt_dc   = {mem_byte, data_counter_reg_ff[7:0]};
			end
			`PSBR_CC_DC_LOAD: begin
				mem_read = 1'b1;
				nxt_pc0  = main_program_counter_ff + 16'h0001;
				nxt_dc   = {mem_byte, data_counter_reg_ff[7:0]};
			end
			`PSBR_CC_BUS_PCLO: begin
				nxt_pc1 = main_program_counter_ff;
				nxt_pc0 = {main_program_counter_ff[15:8], data_in};
			end
			`PSBR_CC_VEC_HI: begin
				nxt_drive = irq_pending;
				nxt_data  = VECTOR[15:8];
				if (irq_pending) begin
					nxt_pc0 = {VECTOR[15:8], main_program_counter_ff[7:0]};
				end
			end
			`PSBR_CC_LD_PC_HI:  nxt_pc0 = {data_in, main_program_counter_ff[7:0]};
			`PSBR_CC_LD_PC1_HI: nxt_pc1 = {data_in, stack_program_counter_ff[7:0]};
			`PSBR_CC_LD_DC_HI:  nxt_dc  = {data_in, data_counter_reg_ff[7:0]};
			`PSBR_CC_LD_PC_LO:  nxt_pc0 = {main_program_counter_ff[15:8], data_in};
			`PSBR_CC_LD_PC1_LO: nxt_pc1 = {stack_program_counter_ff[15:8], data_in};
			`PSBR_CC_LD_DC_LO:  nxt_dc  = {data_counter_reg_ff[15:8], data_in};
			`PSBR_CC_PORT_RD: begin
				nxt_drive = port_a_hit || port_b_hit;
				nxt_data  = port_rd;
			end
			`PSBR_CC_SWAP_DC: nxt_dc = stack_program_counter_ff;
			`PSBR_CC_PC_LO_OUT: begin
				nxt_drive = 1'b1;
				nxt_data  = main_program_counter_ff[7:0];
			end
			`PSBR_CC_PC_HI_OUT: begin
				nxt_drive = 1'b1;
				nxt_data  = main_program_counter_ff[15:8];
			end
			default: begin
				nxt_drive = 1'b0;
			end
		endcase
		if (mem_read) begin
			nxt_drive = in_seg && precharged_ff;
			nxt_data  = mem_byte;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Counters and bus latch move on the write enable; the CPU holds the
	// code and bus data valid up to that edge, so the add has settled
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			main_program_counter_ff  <= `PSBR_ADDR_RST;
			stack_program_counter_ff <= `PSBR_ADDR_RST;
			data_counter_reg_ff      <= `PSBR_ADDR_RST;
			port_a_ff                <= `PSBR_BYTE_RST;
			port_b_ff                <= `PSBR_BYTE_RST;
			data_out                 <= `PSBR_BYTE_RST;
			drive_ff                 <= 1'b0;
		end else if (write_en) begin
			main_program_counter_ff  <= nxt_pc0;
			stack_program_counter_ff <= nxt_pc1;
			data_counter_reg_ff      <= nxt_dc;
			// Byte is latched at cycle start so it is stable all cycle
			data_out                 <= nxt_data;
			drive_ff                 <= nxt_drive;
			if (cycle_control_code == `PSBR_CC_PORT_WR) begin
				if (port_a_hit) begin
					port_a_ff <= data_in;
				end
				if (port_b_hit) begin
					port_b_ff <= data_in;
				end
			end
		end
	end

	// Drive and direction share one flop so the direction output is low
	// exactly while data is on the bus; it clears at the next write enable unless that cycle's code drives too
	assign data_oe             = drive_ff;
	assign bus_direction_n_out = 1'b0;
	assign bus_direction_n_oe  = drive_ff;

	////////////////////////////////////////////////////////////////////
	// Precharge marker and timer prescale on the phase enable
	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			precharged_ff <= 1'b0;
			timer_div_ff  <= 5'h00;
			timer_tick_ff <= 1'b0;
		end else begin
			if (write_en) begin
				precharged_ff <= 1'b0;
			end else if (phase_en) begin
				precharged_ff <= 1'b1;
			end
			timer_tick_ff <= 1'b0;
			if (phase_en) begin
				if (timer_div_ff == 5'h1e) begin
					timer_div_ff  <= 5'h00;
					timer_tick_ff <= 1'b1;
				end else begin
					timer_div_ff <= timer_div_ff + 5'h01;
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- inc/psbr_consts.vh
// Constants for the program store bus responder
`ifndef PSBR_CONSTS_VH
`define PSBR_CONSTS_VH

// Cycle control codes
`define PSBR_CC_FETCH     5'h00
`define PSBR_CC_BRANCH    5'h01
`define PSBR_CC_OPND_DC   5'h02
`define PSBR_CC_OPND_PC   5'h03
`define PSBR_CC_SWAP_PC   5'h04
`define PSBR_CC_STORE_DC  5'h05
`define PSBR_CC_DC_HI     5'h06
`define PSBR_CC_PC1_HI    5'h07
`define PSBR_CC_CLR_PC    5'h08
`define PSBR_CC_DC_LO     5'h09
`define PSBR_CC_ADD_DC    5'h0a
`define PSBR_CC_PC1_LO    5'h0b
`define PSBR_CC_PCLO_MEM  5'h0c
`define PSBR_CC_INC_PC1   5'h0d
`define PSBR_CC_DCLO_MEM  5'h0e
`define PSBR_CC_VEC_LO    5'h0f
`define PSBR_CC_DCHI_MEM  5'h10
`define PSBR_CC_DC_LOAD   5'h11
`define PSBR_CC_BUS_PCLO  5'h12
`define PSBR_CC_VEC_HI    5'h13
`define PSBR_CC_LD_PC_HI  5'h14
`define PSBR_CC_LD_PC1_HI 5'h15
`define PSBR_CC_LD_DC_HI  5'h16
`define PSBR_CC_LD_PC_LO  5'h17
`define PSBR_CC_LD_PC1_LO 5'h18
`define PSBR_CC_LD_DC_LO  5'h19
`define PSBR_CC_PORT_WR   5'h1a
`define PSBR_CC_PORT_RD   5'h1b
`define PSBR_CC_NOP       5'h1c
`define PSBR_CC_SWAP_DC   5'h1d
`define PSBR_CC_PC_LO_OUT 5'h1e
`define PSBR_CC_PC_HI_OUT 5'h1f

// Port decode: low two bits of the port address
`define PSBR_PORT_A_LSB   2'h0
`define PSBR_PORT_B_LSB   2'h1

// Reset values
`define PSBR_ADDR_RST     16'h0000
`define PSBR_BYTE_RST     8'h00

`endif

//--- logic/psbr_addr_adder.v
// Adder/incrementer: 16-bit address plus sign-extended or zero-extended byte
`timescale 1ns/1ps
`default_nettype none

module psbr_addr_adder (
	// Operands
	input  wire [15:0] base,
	input  wire [7:0]  addend,
	input  wire        sign_ext,
	// Result
	output wire [15:0] sum
);

	wire [15:0] ext;

	// Offsets for branches and data-counter adds are two's complement
	assign ext = sign_ext ? {{8{addend[7]}}, addend} : {8'h00, addend};
	assign sum = base + ext;

endmodule

`default_nettype wire

//--- tb/psbr_sva.sv
// Port checks for the program store bus responder
`timescale 1ns/1ps
`default_nettype none
`include "psbr_consts.vh"
module psbr_sva #(
	parameter [5:0]  PORT_SEL = 6'h01,
	parameter [15:0] VECTOR   = 16'h0080
) (
	// Timing
	input wire logic       clock,
	input wire logic       resetn,
	input wire logic       write_en,
	// Bus side
	input wire logic [4:0] cycle_control_code,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       bus_direction_n_out,
	input wire logic       bus_direction_n_oe,
	input wire logic       irq_pending,
	// Ports
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_a_ff
);
default clocking @(posedge clock); endclocking
default disable iff (!resetn);
wire [4:0] cc = cycle_control_code;
wire       tk = write_en;
////////////////////////////////////////////////////////////////
a_dir_follows: assert property (bus_direction_n_oe == data_oe)
	else $error("direction enable differs from data enable");
a_open_drain: assert property (!bus_direction_n_out)
	else $error("direction pin driven high");
a_holds_between: assert property (!tk |=> $stable(data_oe) && $stable(data_out))
	else $error("bus output moved between cycles");
a_idle_off: assert property (tk && cc == `PSBR_CC_NOP |=> !data_oe)
	else $error("bus driven on idle code");
a_vec_refused: assert property (tk && cc inside {5'h0f, 5'h13} && !irq_pending |=> !data_oe)
	else $error("vector driven without interrupt");
a_vec_high: assert property (tk && cc == `PSBR_CC_VEC_HI && irq_pending
	|=> data_oe && data_out == VECTOR[15:8])
	else $error("wrong vector high byte");
a_port_load: assert property (tk && cc == `PSBR_CC_PORT_WR && data_in == {PORT_SEL, 2'h0}
	|=> port_a_ff == $past(data_in) && !data_oe)
	else $error("port latch not loaded");
a_port_read: assert property (tk && cc == `PSBR_CC_PORT_RD && data_in == {PORT_SEL, 2'h1}
	|=> data_oe && data_out == $past(port_b_in))
	else $error("port byte not driven");
a_port_unsel: assert property (tk && cc == `PSBR_CC_PORT_RD && data_in[7:2] != PORT_SEL
	|=> !data_oe)
	else $error("unselected port driven");
c_vec: cover property (tk && cc == `PSBR_CC_VEC_LO && irq_pending);
c_port: cover property (tk && cc == `PSBR_CC_PORT_WR);
c_release: cover property (data_oe ##[1:12] !data_oe);
endmodule
bind psbr_responder psbr_sva #(.PORT_SEL(PORT_SEL), .VECTOR(VECTOR)) chk (.*);
`default_nettype wire

//--- tb/psbr_cpu_model.sv
// CPU timing model: phase and cycle strobes, short or long cycles
`timescale 1ns/1ps
`default_nettype none
module psbr_cpu_model (
	// Timing
	input wire logic  clock,
	input wire logic  resetn,
	input wire logic  long_cyc,
	// Strobes
	output wire logic phase_en,
	output wire logic write_en
);
logic [3:0] cnt_ff;
wire  [3:0] lim = long_cyc ? 4'hb : 4'h7;
////////////////////////////////////////////////////////////////
// Four or six phase periods per cycle; long cycles slow every answer
always @(posedge clock or negedge resetn) begin
	if (!resetn)
		cnt_ff <= 4'h0;
	else
		cnt_ff <= (cnt_ff >= lim) ? 4'h0 : cnt_ff + 4'h1;
end
assign phase_en = cnt_ff[0];
assign write_en = (cnt_ff == lim);
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the program store bus responder
`timescale 1ns/1ps
`default_nettype none
`include "psbr_consts.vh"
module tb;
localparam [15:0] VEC = 16'h1234;
logic       clock = 1'b0;
logic       resetn = 1'b0;
logic       long_cyc = 1'b0;
logic       irq_pending = 1'b0;
logic [4:0] cycle_control_code = 5'h1c;
logic [7:0] cpu_byte = 8'h00;
logic [7:0] port_a_in = 8'hc3;
logic [7:0] port_b_in = 8'h5a;
wire        phase_en, write_en, data_oe, timer_tick_ff;
wire  [7:0] data_out, port_a_ff, port_b_ff;
// The CPU stays off the bus while the responder drives it
wire  [7:0] data_in = data_oe ? data_out : cpu_byte;
int         fails = 0;
int         checks = 0;
always #50 clock = ~clock;
psbr_cpu_model cpu (.clock(clock), .resetn(resetn), .long_cyc(long_cyc),
	.phase_en(phase_en), .write_en(write_en));
psbr_responder #(.PORT_SEL(6'h01), .VECTOR(VEC)) uut (.clock(clock), .resetn(resetn),
	.phase_en(phase_en), .write_en(write_en), .cycle_control_code(cycle_control_code),
	.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .bus_direction_n_out(),
	.bus_direction_n_oe(), .irq_pending(irq_pending), .port_a_in(port_a_in),
	.port_b_in(port_b_in), .port_a_ff(port_a_ff), .port_b_ff(port_b_ff),
	.timer_tick_ff(timer_tick_ff));
////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
	checks++;
	if (g !== e) begin
		fails++;
		$display("ERROR %s expected %h seen %h", nm, e, g);
	end
endtask
task cyc(input logic [4:0] c, input logic [7:0] d, input logic e, input logic [7:0] q);
	int n;
	n = 0;
	@(posedge clock);
	cycle_control_code <= c;
	cpu_byte <= d;
	do begin
		@(posedge clock);
		n++;
	end while (write_en !== 1'b1 && n < 20);
	chk("write_en", 8'h01, {7'h00, write_en});
	#1;
	chk("data_oe", {7'h00, e}, {7'h00, data_oe});
	if (e)
		chk("data_out", q, data_out);
endtask
task t_pc();
	cyc(5'h14, 8'h00, 0, 8'h00);
	cyc(5'h17, 8'h12, 0, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h12);
	cyc(5'h00, 8'h00, 1, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h13);
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h08, 8'h00, 0, 8'h00);
	cyc(5'h1f, 8'h00, 1, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h00);
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h14, 8'h04, 0, 8'h00);
	cyc(5'h00, 8'h00, 0, 8'h00);
endtask
task t_dc();
	cyc(5'h16, 8'h00, 0, 8'h00);
	cyc(5'h19, 8'h10, 0, 8'h00);
	cyc(5'h0a, 8'hfe, 0, 8'h00);
	cyc(5'h06, 8'h00, 1, 8'h00);
	cyc(5'h09, 8'h00, 1, 8'h0e);
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h15, 8'h03, 0, 8'h00);
	cyc(5'h18, 8'hab, 0, 8'h00);
	cyc(5'h07, 8'h00, 1, 8'h03);
	cyc(5'h0b, 8'h00, 1, 8'hab);
endtask
task t_vec();
	cyc(5'h0f, 8'h00, 0, 8'h00);
	cyc(5'h13, 8'h00, 0, 8'h00);
	@(posedge clock);
	irq_pending <= 1'b1;
	cyc(5'h0f, 8'h00, 1, VEC[7:0]);
	cyc(5'h13, 8'h00, 1, VEC[15:8]);
	@(posedge clock);
	irq_pending <= 1'b0;
endtask
task t_misc();
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h14, 8'h00, 0, 8'h00);
	cyc(5'h17, 8'h20, 0, 8'h00);
	cyc(5'h12, 8'h55, 0, 8'h00);
	cyc(5'h0b, 8'h00, 1, 8'h20);
	cyc(5'h1e, 8'h00, 1, 8'h55);
	cyc(5'h0d, 8'h00, 0, 8'h00);
	cyc(5'h0b, 8'h00, 1, 8'h56);
	cyc(5'h1d, 8'h00, 0, 8'h00);
	cyc(5'h09, 8'h00, 1, 8'h56);
	cyc(5'h02, 8'h00, 1, 8'h00);
	cyc(5'h09, 8'h00, 1, 8'h57);
	cyc(5'h05, 8'h00, 0, 8'h00);
	cyc(5'h09, 8'h00, 1, 8'h58);
	cyc(5'h04, 8'h00, 0, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h56);
	cyc(5'h0c, 8'h00, 1, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h00);
	cyc(5'h03, 8'h00, 1, 8'h00);
	cyc(5'h0e, 8'h00, 1, 8'h00);
	cyc(5'h09, 8'h00, 1, 8'h00);
	cyc(5'h10, 8'h00, 1, 8'h00);
	cyc(5'h11, 8'h00, 1, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h04);
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h01, 8'hfe, 1, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h02);
endtask
// Mid-run reset while the bus is driven: outputs and counters clear
task t_reset();
	cyc(5'h1e, 8'h00, 1, 8'h02);
	@(posedge clock);
	resetn <= 1'b0;
	repeat (2) @(posedge clock);
	chk("data_oe", 8'h00, {7'h00, data_oe});
	chk("port_a_ff", 8'h00, port_a_ff);
	resetn <= 1'b1;
	cyc(5'h1f, 8'h00, 1, 8'h00);
	cyc(5'h1e, 8'h00, 1, 8'h00);
endtask
task t_ports();
	@(posedge clock);
	long_cyc <= 1'b1;
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h1a, 8'h04, 0, 8'h00);
	chk("port_a_ff", 8'h04, port_a_ff);
	cyc(5'h1a, 8'h05, 0, 8'h00);
	chk("port_b_ff", 8'h05, port_b_ff);
	cyc(5'h1a, 8'h08, 0, 8'h00);
	chk("port_a_ff", 8'h04, port_a_ff);
	cyc(5'h1b, 8'h05, 1, 8'h5a);
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h1b, 8'h04, 1, 8'hc3);
	cyc(5'h1c, 8'h00, 0, 8'h00);
	cyc(5'h1b, 8'h08, 0, 8'h00);
endtask
task t_timer();
	int n;
	int k;
	n = 0;
	k = 0;
	do begin
		@(posedge clock);
		k++;
	end while (timer_tick_ff !== 1'b1 && k < 200);
	do begin
		@(posedge clock);
		n += (phase_en === 1'b1);
		k++;
	end while (timer_tick_ff !== 1'b1 && k < 400);
	chk("tick spacing", 8'h1f, n[7:0]);
endtask
task print_verdict();
	if (fails == 0 && checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
initial begin
	#500000;
	fails++;
	print_verdict();
end
initial begin
	repeat (8) @(posedge clock);
	resetn <= 1'b1;
	t_pc();
	t_dc();
	t_vec();
	t_misc();
	t_ports();
	t_reset();
	t_timer();
	print_verdict();
end
endmodule
`default_nettype wire
